// *** nes_pkg.sv ***
// Shared constants and types for the erase and unsecure sequencer.
package nes_pkg;

	localparam logic [7:0] NES_OFF_STATUS = 8'h00;
	localparam logic [7:0] NES_OFF_INDEX  = 8'h04;
	localparam logic [7:0] NES_OFF_PWORD  = 8'h08;
	localparam logic [7:0] NES_OFF_MODE   = 8'h0C;
	localparam logic [7:0] NES_OFF_PROT   = 8'h10;
	localparam logic [7:0] NES_OFF_SECURE = 8'h14;

	localparam int NES_ST_CMD_COMPLETE_FLAG   = 7;
	localparam int NES_ST_ACCESS_ERROR_FLAG = 5;
	localparam int NES_ST_PROTECT_VIOLATION_FLAG = 4;
	localparam int NES_ST_VERHI  = 1;
	localparam int NES_ST_VERLO  = 0;

	localparam int NES_MODE_ALL    = 0;
	localparam int NES_MODE_BLOCK  = 1;
	localparam int NES_MODE_SECTOR = 2;
	localparam int NES_MODE_UNSEC  = 3;

	localparam logic [7:0]  NES_OP_ERASE_ALL = 8'h08;
	localparam logic [7:0]  NES_OP_ERASE_BLK = 8'h09;
	localparam logic [7:0]  NES_OP_ERASE_SEC = 8'h0A;
	localparam logic [7:0]  NES_OP_UNSECURE  = 8'h0B;
	localparam logic [2:0]  NES_IDX_HEAD     = 3'h0;
	localparam logic [2:0]  NES_IDX_ADDR     = 3'h1;
	localparam logic [2:0]  NES_IDX_LAST     = 3'h5;
	localparam int          NES_BLK_SEL_BIT  = 7;
	localparam logic [6:0]  NES_BLK_ID_VALID = 7'h00;

	localparam logic [3:0]  NES_RST_MODE   = 4'hF;
	localparam logic [31:0] NES_RST_PROT   = 32'h0000_0000;
	localparam logic        NES_RST_SECURE = 1'b1;

	localparam logic [1:0] NES_RESP_OKAY   = 2'h0;
	localparam logic [1:0] NES_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		NES_SCOPE_ALL    = 2'h0,
		NES_SCOPE_BLOCK  = 2'h1,
		NES_SCOPE_SECTOR = 2'h2
	} nes_scope_t;

	typedef struct packed {
		logic       verify;
		nes_scope_t scope;
		logic       eeprom;
		logic [15:0] addr;
	} nes_arr_cmd_t;

	typedef enum logic [2:0] {
		NES_REG_STATUS = 3'h0,
		NES_REG_INDEX  = 3'h1,
		NES_REG_PWORD  = 3'h2,
		NES_REG_MODE   = 3'h3,
		NES_REG_PROT   = 3'h4,
		NES_REG_SECURE = 3'h5,
		NES_REG_NONE   = 3'h7
	} nes_reg_t;

endpackage

// *** nes_sequencer.sv ***
// Erase-all, block-erase, sector-erase and unsecure command sequencer with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

module nes_sequencer
	import nes_pkg::*;
#(
	parameter int REGION_LSB = 12
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic [2:0]   s_axi_awprot,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic [2:0]   s_axi_arprot,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	output nes_arr_cmd_t      arr_cmd,
	output logic              arr_req,
	input  wire logic         arr_done,
	input  wire logic         arr_err,
	input  wire logic         arr_uncorr,
	output logic              device_secure,
	output logic              cmd_busy
);

	if (REGION_LSB < 2 || REGION_LSB > 12) begin : g_bad_region
		$error("REGION_LSB must lie between 2 and 12.");
	end
	typedef enum logic [5:0] {
		NES_S_IDLE    = 6'b000001,
		NES_S_ERASE   = 6'b000010,
		NES_S_ERWAIT  = 6'b000100,
		NES_S_VERIFY  = 6'b001000,
		NES_S_VFWAIT  = 6'b010000,
		NES_S_FINISH  = 6'b100000
	} nes_state_t;
	function automatic nes_reg_t nes_decode(input logic [7:0] addr);
		nes_reg_t sel;
		sel = NES_REG_NONE;
		if (addr == NES_OFF_STATUS) begin
			sel = NES_REG_STATUS;
		end else if (addr == NES_OFF_INDEX) begin
			sel = NES_REG_INDEX;
		end else if (addr == NES_OFF_PWORD) begin
			sel = NES_REG_PWORD;
		end else if (addr == NES_OFF_MODE) begin
			sel = NES_REG_MODE;
		end else if (addr == NES_OFF_PROT) begin
			sel = NES_REG_PROT;
		end else if (addr == NES_OFF_SECURE) begin
			sel = NES_REG_SECURE;
		end
		return sel;
	endfunction
	nes_state_t   state_r;
	logic         cmd_complete_flag_r;
	logic         access_error_flag_r;
	logic         protect_violation_flag_r;
	logic         verify_error_hi_r;
	logic         verify_error_lo_r;
	logic [2:0]   param_index_r;
	logic [15:0]  cmd_param_word_r [0:5];
	logic [3:0]   mode_allow_r;
	logic [31:0]  prot_r;
	logic         secure_r;
	logic         release_r;
	logic         aw_held_r;
	logic         w_held_r;
	logic [7:0]   awaddr_r;
	logic [31:0]  wdata_r;
	logic [3:0]   wstrb_r;
	logic         wr_go;
	nes_reg_t     wr_sel;
	logic [31:0]  wmask;
	logic         launch;
	logic         chk_acc;
	logic         chk_prot;
	logic [7:0]   op_code;
	logic [7:0]   blk_code;
	logic [15:0]  sec_addr;
	logic [3:0]   region;
	logic [15:0]  blk_prot;
	assign wr_go    = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_sel   = nes_decode(awaddr_r);
	assign wmask    = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign launch   = wr_go && wr_sel == NES_REG_STATUS && wstrb_r[0] && wdata_r[NES_ST_CMD_COMPLETE_FLAG]
		&& cmd_complete_flag_r;
	assign op_code  = cmd_param_word_r[0][15:8];
	assign blk_code = cmd_param_word_r[0][7:0];
	assign sec_addr = cmd_param_word_r[1];
	assign region   = sec_addr[REGION_LSB +: 4];
	assign blk_prot = blk_code[NES_BLK_SEL_BIT] ? prot_r[31:16] : prot_r[15:0];
	// Launch checks; protection is only reported for a well-formed command.
	always_comb begin
		chk_acc  = 1'b0;
		chk_prot = 1'b0;
		case (op_code)
			NES_OP_ERASE_ALL: begin
				chk_acc  = param_index_r != NES_IDX_HEAD || !mode_allow_r[NES_MODE_ALL];
				chk_prot = |prot_r;
			end
			NES_OP_UNSECURE: begin
				chk_acc  = param_index_r != NES_IDX_HEAD || !mode_allow_r[NES_MODE_UNSEC];
				chk_prot = |prot_r;
			end
			NES_OP_ERASE_BLK: begin
				chk_acc  = param_index_r != NES_IDX_ADDR || !mode_allow_r[NES_MODE_BLOCK]
					|| blk_code[6:0] != NES_BLK_ID_VALID;
				chk_prot = |blk_prot;
			end
			NES_OP_ERASE_SEC: begin
				chk_acc  = param_index_r != NES_IDX_ADDR || !mode_allow_r[NES_MODE_SECTOR]
					|| blk_code[6:0] != NES_BLK_ID_VALID
					|| sec_addr[1:0] != 2'h0;
				chk_prot = blk_prot[region];
			end
			default: begin
				chk_acc  = 1'b1;
				chk_prot = 1'b0;
			end
		endcase
	end

	// Write address and data channels are taken independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r     <= 1'b0;
			awaddr_r      <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r     <= 1'b1;
			awaddr_r      <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_go) begin
			aw_held_r     <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r     <= 1'b0;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r     <= 1'b1;
			wdata_r      <= s_axi_wdata;
			wstrb_r      <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_go) begin
			w_held_r     <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= NES_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_sel == NES_REG_NONE) ? NES_RESP_SLVERR : NES_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= NES_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= NES_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			case (nes_decode(s_axi_araddr))
				NES_REG_STATUS: begin
					s_axi_rdata[NES_ST_CMD_COMPLETE_FLAG]   <= cmd_complete_flag_r;
					s_axi_rdata[NES_ST_ACCESS_ERROR_FLAG] <= access_error_flag_r;
					s_axi_rdata[NES_ST_PROTECT_VIOLATION_FLAG] <= protect_violation_flag_r;
					s_axi_rdata[NES_ST_VERHI]  <= verify_error_hi_r;
					s_axi_rdata[NES_ST_VERLO]  <= verify_error_lo_r;
				end
				NES_REG_INDEX: begin
					s_axi_rdata[2:0] <= param_index_r;
				end
				NES_REG_PWORD: begin
					s_axi_rdata[15:0] <= (param_index_r <= NES_IDX_LAST) ?
						cmd_param_word_r[param_index_r] : 16'h0000;
				end
				NES_REG_MODE: begin
					s_axi_rdata[3:0] <= mode_allow_r;
				end
				NES_REG_PROT: begin
					s_axi_rdata <= prot_r;
				end
				NES_REG_SECURE: begin
					s_axi_rdata[0] <= secure_r;
				end
				default: begin
					s_axi_rresp <= NES_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// Parameter and configuration writes are dropped while a command runs, so a stray
	// write cannot alter an erase in flight.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			param_index_r <= 3'h0;
			mode_allow_r  <= NES_RST_MODE;
			prot_r        <= NES_RST_PROT;
		end else if (wr_go && cmd_complete_flag_r) begin
			if (wr_sel == NES_REG_INDEX && wstrb_r[0]) begin
				param_index_r <= wdata_r[2:0];
			end else if (wr_sel == NES_REG_MODE && wstrb_r[0]) begin
				mode_allow_r <= wdata_r[3:0];
			end else if (wr_sel == NES_REG_PROT) begin
				prot_r <= (prot_r & ~wmask) | (wdata_r & wmask);
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i <= 5; i++) begin
				cmd_param_word_r[i] <= 16'h0000;
			end
		end else if (wr_go && cmd_complete_flag_r && wr_sel == NES_REG_PWORD
			&& param_index_r <= NES_IDX_LAST) begin
			if (wstrb_r[1]) begin
				cmd_param_word_r[param_index_r][15:8] <= wdata_r[15:8];
			end
			if (wstrb_r[0]) begin
				cmd_param_word_r[param_index_r][7:0] <= wdata_r[7:0];
			end
		end
	end
	// Error flags clear on writing one; a flag raised in the same cycle wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			access_error_flag_r      <= 1'b0;
			protect_violation_flag_r <= 1'b0;
		end else begin
			if (launch && chk_acc) begin
				access_error_flag_r <= 1'b1;
			end else if (wr_go && wr_sel == NES_REG_STATUS && wstrb_r[0] && wdata_r[NES_ST_ACCESS_ERROR_FLAG]) begin
				access_error_flag_r <= 1'b0;
			end
			if (launch && !chk_acc && chk_prot) begin
				protect_violation_flag_r <= 1'b1;
			end else if (wr_go && wr_sel == NES_REG_STATUS && wstrb_r[0] && wdata_r[NES_ST_PROTECT_VIOLATION_FLAG]) begin
				protect_violation_flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r             <= NES_S_IDLE;
			cmd_complete_flag_r <= 1'b1;
			release_r           <= 1'b0;
			arr_req             <= 1'b0;
			arr_cmd             <= '0;
		end else begin
			arr_req <= 1'b0;
			case (state_r)
				NES_S_IDLE: begin
					if (launch && !chk_acc && !chk_prot) begin
						cmd_complete_flag_r <= 1'b0;
						release_r           <= op_code == NES_OP_ERASE_ALL || op_code == NES_OP_UNSECURE;
						arr_cmd.eeprom      <= blk_code[NES_BLK_SEL_BIT];
						arr_cmd.addr        <= sec_addr;
						arr_cmd.verify      <= 1'b0;
						if (op_code == NES_OP_ERASE_BLK) begin
							arr_cmd.scope <= NES_SCOPE_BLOCK;
						end else if (op_code == NES_OP_ERASE_SEC) begin
							arr_cmd.scope <= NES_SCOPE_SECTOR;
						end else begin
							arr_cmd.scope <= NES_SCOPE_ALL;
						end
						state_r <= NES_S_ERASE;
					end
				end
				NES_S_ERASE: begin
					arr_req <= 1'b1;
					state_r <= NES_S_ERWAIT;
				end
				NES_S_ERWAIT: begin
					if (arr_done) begin
						state_r <= NES_S_VERIFY;
					end
				end
				NES_S_VERIFY: begin
					arr_cmd.verify <= 1'b1;
					arr_req        <= 1'b1;
					state_r        <= NES_S_VFWAIT;
				end
				NES_S_VFWAIT: begin
					if (arr_done) begin
						state_r <= NES_S_FINISH;
					end
				end
				NES_S_FINISH: begin
					cmd_complete_flag_r <= 1'b1;
					release_r           <= 1'b0;
					arr_cmd.verify      <= 1'b0;
					state_r             <= NES_S_IDLE;
				end
				default: begin
					state_r             <= NES_S_IDLE;
					cmd_complete_flag_r <= 1'b1;
				end
			endcase
		end
	end
	// Verify status is cleared by each accepted launch and sampled when verify ends.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			verify_error_hi_r <= 1'b0;
			verify_error_lo_r <= 1'b0;
		end else if (state_r == NES_S_VFWAIT && arr_done) begin
			verify_error_hi_r <= arr_err || arr_uncorr;
			verify_error_lo_r <= arr_uncorr;
		end else if (state_r == NES_S_IDLE && launch && !chk_acc && !chk_prot) begin
			verify_error_hi_r <= 1'b0;
			verify_error_lo_r <= 1'b0;
		end
	end
	// Security is only ever released here; relocking is left to the reset value.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			secure_r <= NES_RST_SECURE;
		end else if (state_r == NES_S_VFWAIT && arr_done && release_r && !arr_err && !arr_uncorr) begin
			secure_r <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			device_secure <= NES_RST_SECURE;
			cmd_busy      <= 1'b0;
		end else begin
			device_secure <= secure_r;
			cmd_busy      <= !cmd_complete_flag_r;
		end
	end

endmodule

`default_nettype wire

// *** nes_sequencer_asserts.sv ***
// Concurrent checks on the sequencer's array handshake, busy and security outputs.
`timescale 1ns/1ps
`default_nettype none
module nes_sequencer_asserts
	import nes_pkg::*;
(
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire nes_arr_cmd_t arr_cmd,
	input wire logic         arr_req,
	input wire logic         arr_done,
	input wire logic         arr_err,
	input wire logic         arr_uncorr,
	input wire logic         device_secure,
	input wire logic         cmd_busy
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_req_pulse;
		arr_req |=> !arr_req;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("array request longer than one cycle");
	property p_erase_first;
		$rose(cmd_busy) |-> arr_req && !arr_cmd.verify;
	endproperty
	a_erase_first: assert property (p_erase_first) else $error("command did not start with an erase");
	property p_verify_next;
		arr_done && !arr_cmd.verify && cmd_busy |-> ##2 arr_req && arr_cmd.verify;
	endproperty
	a_verify_next: assert property (p_verify_next) else $error("no verify right after erase");
	property p_done_ends;
		arr_done && arr_cmd.verify && cmd_busy |-> ##3 !cmd_busy;
	endproperty
	a_done_ends: assert property (p_done_ends) else $error("busy stayed after verify");
	property p_end_cause;
		$fell(cmd_busy) |-> $past(arr_done && arr_cmd.verify, 3);
	endproperty
	a_end_cause: assert property (p_end_cause) else $error("busy ended without a verify");
	property p_req_busy;
		arr_req |-> cmd_busy;
	endproperty
	a_req_busy: assert property (p_req_busy) else $error("array request outside a command");
	// Security may only drop two edges after a clean verify of a whole-space erase.
	property p_sec_release;
		$fell(device_secure) |->
			$past(arr_done && arr_cmd.verify && !arr_err && !arr_uncorr && arr_cmd.scope == NES_SCOPE_ALL, 2);
	endproperty
	a_sec_release: assert property (p_sec_release) else $error("security released without clean verify");
	property p_sec_kept;
		arr_done && arr_cmd.verify && (arr_err || arr_uncorr) |=> $stable(device_secure) [*2];
	endproperty
	a_sec_kept: assert property (p_sec_kept) else $error("security changed after failed verify");
endmodule
bind nes_sequencer nes_sequencer_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .arr_cmd(arr_cmd),
	.arr_req(arr_req), .arr_done(arr_done), .arr_err(arr_err), .arr_uncorr(arr_uncorr),
	.device_secure(device_secure), .cmd_busy(cmd_busy));
`default_nettype wire

// *** nes_sequencer_test.sv ***
// Self-checking register-level testbench for the erase and unsecure sequencer.
`timescale 1ns/1ps
`default_nettype none
module nes_sequencer_test
	import nes_pkg::*;
;
	logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic         awready, wready, bvalid, arready, rvalid, arr_req, device_secure, cmd_busy;
	logic         arr_done, arr_err, arr_uncorr, pend, v_err, v_unc;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata, rdv;
	logic [1:0]   bresp, rresp, rsp;
	nes_arr_cmd_t arr_cmd, lc;
	int           n_fail, checks, nreq, dly, cnt;
	logic [7:0]   ops [4] = '{NES_OP_ERASE_ALL, NES_OP_ERASE_BLK, NES_OP_ERASE_SEC, NES_OP_UNSECURE};

	nes_sequencer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .arr_cmd(arr_cmd), .arr_req(arr_req), .arr_done(arr_done), .arr_err(arr_err),
		.arr_uncorr(arr_uncorr), .device_secure(device_secure), .cmd_busy(cmd_busy));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Array stand-in: answers each request dly+1 cycles later, verify faults only on the verify pass.
	always @(posedge aclk) begin
		arr_done <= 1'b0;
		if (arr_req === 1'b1) begin
			pend <= 1'b1;
			cnt <= dly;
			nreq <= nreq + 1;
			if (!arr_cmd.verify) lc <= arr_cmd;
		end else if (pend && cnt == 0) begin
			pend <= 1'b0;
			arr_done <= 1'b1;
			arr_err <= v_err & arr_cmd.verify;
			arr_uncorr <= v_unc & arr_cmd.verify;
		end else if (pend) cnt <= cnt - 1;
	end

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic hang();
		n_fail++;
		$display("[FAIL] bus wait expected answer seen none");
		complete_run();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		rsp = bresp;
		if (n == 100) hang();
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		rdv = rdata;
		rsp = rresp;
		if (n == 100) hang();
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask

	// Loads both parameter words, sets the index, launches and polls until the complete flag returns.
	// No other register is written while the flag is low, as software must not touch the module then.
	task automatic run(input logic [7:0] op, input logic [7:0] blk, input logic [15:0] adr,
		input logic [2:0] idx, input logic [7:0] exp, input logic [7:0] msk);
		int n;
		int n0;
		wr(NES_OFF_INDEX, 32'h0);
		wr(NES_OFF_PWORD, {16'h0, op, blk});
		wr(NES_OFF_INDEX, 32'h1);
		wr(NES_OFF_PWORD, {16'h0, adr});
		wr(NES_OFF_INDEX, {29'h0, idx});
		n0 = nreq;
		wr(NES_OFF_STATUS, 32'hB0);
		for (n = 0; n < 60; n++) begin
			rd(NES_OFF_STATUS);
			if (rdv[NES_ST_CMD_COMPLETE_FLAG] === 1'b1) break;
		end
		if (n == 60) hang();
		chk("status", rdv & {24'h0, msk}, {24'h0, exp});
		chk("busy idle", {31'h0, cmd_busy}, 32'h0);
		if (exp[NES_ST_ACCESS_ERROR_FLAG] || exp[NES_ST_PROTECT_VIOLATION_FLAG]) chk("requests", 32'(nreq - n0), 32'h0);
		else chk("requests", 32'(nreq - n0), 32'h2);
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, arr_done, arr_err, arr_uncorr, pend, v_err, v_unc} <= '0;
		awaddr <= 8'h00;
		araddr <= 8'h00;
		wdata <= 32'h0;
		{n_fail, checks, nreq, dly, cnt} = '0;
		do_reset();
		rd(NES_OFF_STATUS);
		chk("status reset", rdv, 32'h80);
		rd(NES_OFF_MODE);
		chk("mode reset", rdv, 32'hF);
		rd(NES_OFF_PROT);
		chk("prot reset", rdv, 32'h0);
		rd(NES_OFF_SECURE);
		chk("secure reset", rdv, 32'h1);
		rd(8'h18);
		chk("rresp unmapped", 32'(rsp), 32'(NES_RESP_SLVERR));
		wr(8'h1C, 32'h1);
		chk("bresp unmapped", 32'(rsp), 32'(NES_RESP_SLVERR));
		$display("test reset values done");
		run(NES_OP_ERASE_ALL, 8'h00, 16'h0, 3'h1, 8'hA0, 8'hF0);
		run(NES_OP_UNSECURE, 8'h00, 16'h0, 3'h1, 8'hA0, 8'hF0);
		run(NES_OP_ERASE_BLK, 8'h00, 16'h0, 3'h0, 8'hA0, 8'hF0);
		run(NES_OP_ERASE_BLK, 8'h01, 16'h0, 3'h1, 8'hA0, 8'hF0);
		run(NES_OP_ERASE_SEC, 8'h00, 16'h0002, 3'h1, 8'hA0, 8'hF0);
		for (int i = 0; i < 4; i++) begin
			wr(NES_OFF_MODE, 32'(4'hF ^ (4'h1 << i)));
			run(ops[i], 8'h00, 16'h0, (i == 1 || i == 2) ? 3'h1 : 3'h0, 8'hA0, 8'hF0);
		end
		wr(NES_OFF_MODE, 32'hF);
		$display("test access errors done");
		wr(NES_OFF_PROT, 32'h1);
		run(NES_OP_ERASE_ALL, 8'h00, 16'h0, 3'h0, 8'h90, 8'hF0);
		run(NES_OP_UNSECURE, 8'h00, 16'h0, 3'h0, 8'h90, 8'hF0);
		run(NES_OP_ERASE_BLK, 8'h00, 16'h0, 3'h1, 8'h90, 8'hF0);
		run(NES_OP_ERASE_SEC, 8'h00, 16'h0004, 3'h1, 8'h90, 8'hF0);
		dly = 4;
		run(NES_OP_ERASE_BLK, 8'h80, 16'h0, 3'h1, 8'h80, 8'hFF);
		chk("block cmd", {12'h0, lc}, {12'h0, 1'b0, NES_SCOPE_BLOCK, 1'b1, 16'h0000});
		run(NES_OP_ERASE_SEC, 8'h00, 16'h1234, 3'h1, 8'h80, 8'hFF);
		chk("sector cmd", {12'h0, lc}, {12'h0, 1'b0, NES_SCOPE_SECTOR, 1'b0, 16'h1234});
		wr(NES_OFF_PROT, 32'h0);
		$display("test protection done");
		v_err = 1'b1;
		run(NES_OP_ERASE_BLK, 8'h00, 16'h0, 3'h1, 8'h82, 8'hFF);
		v_err = 1'b0;
		v_unc = 1'b1;
		dly = 0;
		run(NES_OP_ERASE_ALL, 8'h00, 16'h0, 3'h0, 8'h83, 8'hFF);
		rd(NES_OFF_SECURE);
		chk("secure kept", rdv, 32'h1);
		v_unc = 1'b0;
		run(NES_OP_ERASE_ALL, 8'h00, 16'h0, 3'h0, 8'h80, 8'hFF);
		chk("all cmd", {12'h0, lc}, {12'h0, 1'b0, NES_SCOPE_ALL, 1'b0, 16'h0000});
		rd(NES_OFF_SECURE);
		chk("secure released", rdv, 32'h0);
		chk("device_secure", {31'h0, device_secure}, 32'h0);
		$display("test erase all done");
		do_reset();
		v_err = 1'b1;
		run(NES_OP_UNSECURE, 8'h00, 16'h0, 3'h0, 8'h82, 8'hFF);
		rd(NES_OFF_SECURE);
		chk("secure after fail", rdv, 32'h1);
		v_err = 1'b0;
		dly = 3;
		run(NES_OP_UNSECURE, 8'h00, 16'h0, 3'h0, 8'h80, 8'hFF);
		rd(NES_OFF_SECURE);
		chk("secure after unsecure", rdv, 32'h0);
		$display("test unsecure done");
		complete_run();
	end
endmodule
`default_nettype wire
